// file: rtl/sec_attr_pkg.sv
package sec_attr_pkg;
    localparam int NUM_REGIONS   = 8;
    localparam int NUM_PERIPH    = 16;
    localparam int NUM_GPIO      = 32;
    localparam int NUM_IRQ       = 32;
    localparam int NUM_VIOL_SRC  = 8;
    localparam int TOP_BIT       = 31;
    localparam int NIB_LSB       = 28;
    localparam int TZ_ENABLE_BIT = 0;
    localparam int OPT_W         = 32;

    localparam logic [31:0] NSC_FLASH_LO  = 32'h0C00_0000;
    localparam logic [31:0] NSC_FLASH_HI  = 32'h0FFF_FFFF;
    localparam logic [3:0]  NIB_SRAM_NS   = 4'h2;
    localparam logic [3:0]  NIB_SRAM_S    = 4'h3;
    localparam logic [3:0]  NIB_PERIPH_NS = 4'h4;
    localparam logic [3:0]  NIB_PERIPH_S  = 4'h5;
    localparam logic [31:0] MAP_TOP       = 32'hDFFF_FFFF;
    localparam logic [31:0] FLASH_NS_LO   = 32'h0800_0000;
    localparam logic [31:0] FLASH_NS_HI   = 32'h0BFF_FFFF;

    // Ordered so that a larger code is more secure
    typedef enum logic [1:0] {
        ATTR_NS  = 2'h0,
        ATTR_NSC = 2'h1,
        ATTR_S   = 2'h2
    } attr_t;

    typedef struct packed {
        logic        enable;
        logic [31:0] base;
        logic [31:0] limit;
        logic        callable;
    } region_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic        secure;
    } access_t;

    typedef struct packed {
        logic  violation;
        attr_t attr;
        logic  secure_view;
    } verdict_t;
endpackage : sec_attr_pkg

// file: rtl/security_attribution_map.sv
module security_attribution_map
    import sec_attr_pkg::*;
(
    input  wire logic                          clock,
    input  wire logic                          rst_n,
    input  wire logic [sec_attr_pkg::OPT_W-1:0] flash_option_word,
    input  wire logic [31:0]                   wm_secure_lo,
    input  wire logic [31:0]                   wm_secure_hi,
    input  wire logic [31:0]                   boot_addr,
    input  wire logic                          region_we,
    input  wire logic [2:0]                    region_idx,
    input  wire sec_attr_pkg::region_t         region_wdata,
    input  wire logic                          all_ns_we,
    input  wire logic                          all_ns_wdata,
    input  wire sec_attr_pkg::access_t         access,
    input  wire logic                          cfg_we,
    input  wire logic [sec_attr_pkg::NUM_PERIPH-1:0] periph_sec_wdata,
    input  wire logic [sec_attr_pkg::NUM_PERIPH-1:0] periph_priv_wdata,
    input  wire logic [sec_attr_pkg::NUM_GPIO-1:0]   gpio_sec_wdata,
    input  wire logic [sec_attr_pkg::NUM_IRQ-1:0]    irq_sec_wdata,
    input  wire logic                          sram_sec_wdata,
    input  wire logic                          blk_flash_sec_wdata,
    input  wire logic [sec_attr_pkg::NUM_VIOL_SRC-1:0] viol_src,
    input  wire logic [sec_attr_pkg::NUM_VIOL_SRC-1:0] viol_en_wdata,
    input  wire logic                          viol_en_we,
    input  wire logic [sec_attr_pkg::NUM_VIOL_SRC-1:0] viol_clr,
    output logic                               tz_active,
    output sec_attr_pkg::verdict_t             verdict,
    output logic                               cpu_secure,
    output logic                               boot_ok,
    output logic [sec_attr_pkg::NUM_PERIPH-1:0] periph_secure,
    output logic [sec_attr_pkg::NUM_PERIPH-1:0] periph_priv,
    output logic [sec_attr_pkg::NUM_GPIO-1:0]   gpio_secure,
    output logic [sec_attr_pkg::NUM_IRQ-1:0]    irq_secure,
    output logic                               sram_secure,
    output logic                               sram_prot_cfg_secure,
    output logic                               blk_flash_secure,
    output logic [sec_attr_pkg::NUM_VIOL_SRC-1:0] viol_pending,
    output logic                               viol_irq
);
    import sec_attr_pkg::*;

    // ------------------------------------------------------------
    // Option capture
    // ------------------------------------------------------------
    // Options are latched after reset release, never from ports under reset
    logic        opt_loaded_r;
    logic        tz_en_r;
    logic [31:0] wm_lo_r;
    logic [31:0] wm_hi_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            opt_loaded_r <= 1'b0;
            tz_en_r      <= 1'b0;
            wm_lo_r      <= 32'h0000_0000;
            wm_hi_r      <= 32'h0000_0000;
        end else if (!opt_loaded_r) begin
            opt_loaded_r <= 1'b1;
            tz_en_r      <= flash_option_word[TZ_ENABLE_BIT];
            wm_lo_r      <= wm_secure_lo;
            wm_hi_r      <= wm_secure_hi;
        end
    end

    // ------------------------------------------------------------
    // Programmable regions
    // ------------------------------------------------------------
    region_t regions_r [NUM_REGIONS];
    logic    all_ns_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            all_ns_r <= 1'b0;
        end else if (all_ns_we) begin
            all_ns_r <= all_ns_wdata;
        end
    end

    logic [NUM_REGIONS-1:0] hit;
    logic [NUM_REGIONS-1:0] hit_nsc;

    genvar g;
    generate
        for (g = 0; g < NUM_REGIONS; g++) begin : g_region
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    regions_r[g] <= '0;
                end else if (region_we && region_idx == 3'(g)) begin
                    regions_r[g] <= region_wdata;
                end
            end
            assign hit[g]     = regions_r[g].enable &&
                                access.addr >= regions_r[g].base &&
                                access.addr <= regions_r[g].limit;
            assign hit_nsc[g] = hit[g] && regions_r[g].callable;
        end
    endgenerate

    // ------------------------------------------------------------
    // Attribution
    // ------------------------------------------------------------
    attr_t    fixed_attr;
    attr_t    region_attr;
    attr_t    final_attr;
    logic     in_wm;
    logic [3:0] nib;

    always_comb begin
        nib = access.addr[TOP_BIT:NIB_LSB];
        if ((access.addr >= NSC_FLASH_LO && access.addr <= NSC_FLASH_HI) ||
            nib == NIB_SRAM_S || nib == NIB_PERIPH_S) begin
            fixed_attr = ATTR_NSC;
        end else begin
            fixed_attr = ATTR_NS;
        end
        // Regions default to secure; only a hit or the open switch lowers it
        if (!all_ns_r && hit == '0) begin
            region_attr = ATTR_S;
        end else if (hit_nsc != '0) begin
            region_attr = ATTR_NSC;
        end else if (hit != '0) begin
            region_attr = ATTR_NS;
        end else begin
            region_attr = ATTR_NS;
        end
        final_attr = (fixed_attr > region_attr) ? fixed_attr : region_attr;
        // Watermark area of flash is secure regardless of region setup
        in_wm = access.addr[NIB_LSB-1:0] >= wm_lo_r[NIB_LSB-1:0] &&
                access.addr[NIB_LSB-1:0] <= wm_hi_r[NIB_LSB-1:0] &&
                access.addr >= FLASH_NS_LO && access.addr <= NSC_FLASH_HI;
        if (in_wm) begin
            final_attr = ATTR_S;
        end
        if (access.addr > MAP_TOP) begin
            final_attr = ATTR_S;
        end
    end

    // ------------------------------------------------------------
    // Verdict
    // ------------------------------------------------------------
    // Registered one cycle after the address; the attribute itself is combinational
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            verdict   <= '0;
            tz_active <= 1'b0;
        end else begin
            tz_active           <= tz_en_r;
            verdict.attr        <= tz_en_r ? final_attr : ATTR_NS;
            verdict.secure_view <= tz_en_r && fixed_attr == ATTR_NSC;
            verdict.violation   <= tz_en_r && access.valid && !access.secure &&
                                   final_attr != ATTR_NS;
        end
    end

    // ------------------------------------------------------------
    // Reset security state and boot
    // ------------------------------------------------------------
    logic boot_in_secure;
    assign boot_in_secure = boot_addr >= NSC_FLASH_LO && boot_addr <= NSC_FLASH_HI;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cpu_secure <= 1'b1;
            boot_ok    <= 1'b0;
        end else begin
            cpu_secure <= 1'b1;
            boot_ok    <= !tz_en_r || boot_in_secure;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            periph_secure        <= '0;
            periph_priv          <= '0;
            gpio_secure          <= '1;
            irq_secure           <= '1;
            sram_secure          <= 1'b1;
            sram_prot_cfg_secure <= 1'b1;
            blk_flash_secure     <= 1'b0;
        end else if (cfg_we && tz_en_r) begin
            periph_secure    <= periph_sec_wdata;
            periph_priv      <= periph_priv_wdata;
            gpio_secure      <= gpio_sec_wdata;
            irq_secure       <= irq_sec_wdata;
            sram_secure      <= sram_sec_wdata;
            blk_flash_secure <= blk_flash_sec_wdata;
        end
    end
    // security-aware peripherals read periph_secure and gate their own registers

    // ------------------------------------------------------------
    // Illegal access collection
    // ------------------------------------------------------------
    logic [NUM_VIOL_SRC-1:0] viol_en_r;
    logic [NUM_VIOL_SRC-1:0] src_all;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            viol_en_r <= '0;
        end else if (viol_en_we) begin
            viol_en_r <= viol_en_wdata;
        end
    end

    // Source 0 is viol_src[0] ORed with this block's own attribution check
    assign src_all = {viol_src[NUM_VIOL_SRC-1:1], viol_src[0] | verdict.violation};

    // Set wins over clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            viol_pending <= '0;
            viol_irq     <= 1'b0;
        end else begin
            viol_pending <= (viol_pending & ~viol_clr) | (src_all & viol_en_r);
            viol_irq     <= |((viol_pending & ~viol_clr) | (src_all & viol_en_r));
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_disabled_no_violation: assert property (@(posedge clock) disable iff (!rst_n)
        !tz_en_r |=> !verdict.violation && verdict.attr == ATTR_NS)
        else $error("violation while partitioning disabled");

    a_reset_all_secure: assert property (@(posedge clock) disable iff (!rst_n)
        (tz_en_r && !all_ns_r && hit == '0 && access.valid && !access.secure &&
         access.addr <= MAP_TOP) |=> verdict.violation)
        else $error("unconfigured address not secure");

    a_more_secure_kept: assert property (@(posedge clock) disable iff (!rst_n)
        tz_en_r |=> verdict.attr >= $past(fixed_attr))
        else $error("final attribute below fixed map");

    a_ns_callable_map: assert property (@(posedge clock) disable iff (!rst_n)
        (tz_en_r && access.addr[TOP_BIT:NIB_LSB] == NIB_PERIPH_S) |=>
        verdict.secure_view && verdict.attr != ATTR_NS)
        else $error("peripheral alias not callable");

    a_top_secure: assert property (@(posedge clock) disable iff (!rst_n)
        (tz_en_r && access.addr > MAP_TOP) |=> verdict.attr == ATTR_S)
        else $error("address above map not secure");

    a_wm_secure: assert property (@(posedge clock) disable iff (!rst_n)
        (tz_en_r && in_wm) |=> verdict.attr == ATTR_S)
        else $error("watermark area not secure");

    a_options_held: assert property (@(posedge clock) disable iff (!rst_n)
        opt_loaded_r |=> opt_loaded_r && $stable(tz_en_r) && $stable(wm_lo_r) && $stable(wm_hi_r))
        else $error("option values changed after load");

    a_region_callable: assert property (@(posedge clock) disable iff (!rst_n)
        (tz_en_r && hit_nsc != '0 && fixed_attr == ATTR_NS && !in_wm &&
         access.addr <= MAP_TOP) |=> verdict.attr == ATTR_NSC)
        else $error("callable region not applied");

    // ------------------------------------------------------------
    // Violation steps
    // ------------------------------------------------------------
    sequence s_ns_into_secure;
        tz_en_r && access.valid && !access.secure && final_attr == ATTR_S;
    endsequence

    sequence s_flag_then_pend;
        verdict.violation ##1 (viol_pending[0] || !viol_en_r[0] || $past(viol_clr[0]));
    endsequence

    a_viol_flagged: assert property (@(posedge clock) disable iff (!rst_n)
        s_ns_into_secure |=> s_flag_then_pend)
        else $error("violation not flagged");

    // Set must win even when the clear lands in the same cycle
    a_pending_set: assert property (@(posedge clock) disable iff (!rst_n)
        (viol_en_r[0] && src_all[0]) |=> viol_pending[0])
        else $error("enabled source not pending");

    a_disabled_no_irq: assert property (@(posedge clock) disable iff (!rst_n)
        (viol_en_r == '0 && viol_pending == '0 && viol_en_r == $past(viol_en_r)) |=> !viol_irq)
        else $error("interrupt from disabled source");

    a_irq_follows_pending: assert property (@(posedge clock) disable iff (!rst_n)
        viol_irq == (viol_pending != '0))
        else $error("interrupt not matching pending");

    a_cpu_secure: assert property (@(posedge clock) disable iff (!rst_n)
        cpu_secure)
        else $error("cpu not secure");

    a_boot_secure: assert property (@(posedge clock) disable iff (!rst_n)
        (tz_en_r && !boot_in_secure) |=> !boot_ok)
        else $error("boot outside secure area accepted");

    a_cfg_ignored_off: assert property (@(posedge clock) disable iff (!rst_n)
        (!tz_en_r && cfg_we) |=> $stable(periph_secure) && $stable(irq_secure) &&
        $stable(sram_secure))
        else $error("configuration taken while disabled");

    a_cfg_locked_off: assert property (@(posedge clock) disable iff (!rst_n)
        !tz_en_r |=> gpio_secure == $past(gpio_secure))
        else $error("gpio security changed while disabled");

    a_reset_defaults: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(opt_loaded_r) |-> sram_secure && sram_prot_cfg_secure && !blk_flash_secure)
        else $error("memory reset state wrong");
endmodule : security_attribution_map

// file: sim/access_master.sv
module access_master
    import sec_attr_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             go,
    input  wire logic [31:0]      addr,
    input  wire logic             sec,
    output sec_attr_pkg::access_t access
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle fields toggle so that a stale request is never read as a fresh one
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            access <= '0;
        end else if (go) begin
            access <= '{valid: 1'b1, addr: addr, secure: sec};
        end else begin
            access <= '{valid: 1'b0, addr: ~access.addr, secure: ~access.secure};
        end
    end
endmodule : access_master

// file: sim/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import sec_attr_pkg::*;

    logic        clock, rst_n, go, sec, region_we, all_ns_we, all_ns_wdata, cfg_we, tz, ans;
    logic        viol_en_we, sram_sec_wdata, blk_flash_sec_wdata, tz_active, cpu_secure;
    logic        boot_ok, sram_secure, sram_prot_cfg_secure, blk_flash_secure, viol_irq;
    logic [31:0] flash_option_word, wm_secure_lo, wm_secure_hi, boot_addr, addr, v, pick;
    logic [31:0] gpio_sec_wdata, irq_sec_wdata, gpio_secure, irq_secure;
    logic [15:0] periph_sec_wdata, periph_priv_wdata, periph_secure, periph_priv;
    logic [7:0]  viol_src, viol_en_wdata, viol_clr, viol_pending, pend;
    logic [2:0]  region_idx;
    region_t     region_wdata, r;
    region_t     rg [8];
    access_t     access;
    verdict_t    verdict;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    int          seed = 61291;
    logic [31:0] corner [10] = '{32'h0BFF_FFFF, 32'h0C00_0000, 32'h0FFF_FFFF, 32'h1000_0000,
        32'h2FFF_FFFF, 32'h3000_0000, 32'h4FFF_FFFF, 32'h5000_0000, 32'hDFFF_FFFF, 32'hE000_0000};

    security_attribution_map i_security_attribution_map (
        .clock(clock), .rst_n(rst_n), .flash_option_word(flash_option_word),
        .wm_secure_lo(wm_secure_lo), .wm_secure_hi(wm_secure_hi), .boot_addr(boot_addr),
        .region_we(region_we), .region_idx(region_idx), .region_wdata(region_wdata),
        .all_ns_we(all_ns_we), .all_ns_wdata(all_ns_wdata), .access(access), .cfg_we(cfg_we),
        .periph_sec_wdata(periph_sec_wdata), .periph_priv_wdata(periph_priv_wdata),
        .gpio_sec_wdata(gpio_sec_wdata), .irq_sec_wdata(irq_sec_wdata),
        .sram_sec_wdata(sram_sec_wdata), .blk_flash_sec_wdata(blk_flash_sec_wdata),
        .viol_src(viol_src), .viol_en_wdata(viol_en_wdata), .viol_en_we(viol_en_we),
        .viol_clr(viol_clr), .tz_active(tz_active), .verdict(verdict), .cpu_secure(cpu_secure),
        .boot_ok(boot_ok), .periph_secure(periph_secure), .periph_priv(periph_priv),
        .gpio_secure(gpio_secure), .irq_secure(irq_secure), .sram_secure(sram_secure),
        .sram_prot_cfg_secure(sram_prot_cfg_secure), .blk_flash_secure(blk_flash_secure),
        .viol_pending(viol_pending), .viol_irq(viol_irq));
    access_master i_access_master (
        .clock(clock), .rst_n(rst_n), .go(go), .addr(addr), .sec(sec), .access(access));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial begin
        repeat (100000) @(posedge clock);
        n_mismatch++;
        print_verdict();
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict;
        $display("compares %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    task automatic defaults;
        check({cpu_secure, sram_secure, sram_prot_cfg_secure, blk_flash_secure}, 4'hE);
        check({gpio_secure, irq_secure}, 64'hFFFF_FFFF_FFFF_FFFF);
        check({periph_secure, periph_priv, viol_pending, viol_irq}, 64'h0);
    endtask : defaults

    task automatic do_reset(input logic t);
        @(posedge clock);
        rst_n <= 1'b0;
        flash_option_word <= ($random(seed) & 32'hFFFF_FFFE) | {31'h0, t};
        tz = t;
        ans = 1'b0;
        rg = '{default: '0};
        repeat (3) @(posedge clock);
        #1 defaults();
        @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        #1 check(tz_active, t);
        defaults();
    endtask : do_reset

    task automatic boot(input logic [31:0] a, input logic e);
        @(posedge clock);
        boot_addr <= a;
        repeat (2) @(posedge clock);
        #1 check(boot_ok, e);
    endtask : boot

    function automatic attr_t fix_attr(input logic [31:0] a);
        if (a > MAP_TOP) return ATTR_S;
        if ((a >= NSC_FLASH_LO && a <= NSC_FLASH_HI) || a[31:28] == NIB_SRAM_S
            || a[31:28] == NIB_PERIPH_S) return ATTR_NSC;
        return ATTR_NS;
    endfunction : fix_attr

    function automatic attr_t fin_attr(input logic [31:0] a);
        attr_t x;
        logic  hit;
        logic  chit;
        hit = 1'b0;
        chit = 1'b0;
        foreach (rg[i]) begin
            if (rg[i].enable && a >= rg[i].base && a <= rg[i].limit) begin
                hit = 1'b1;
                chit = chit | rg[i].callable;
            end
        end
        // With no region hit the default is secure until cleared
        x = chit ? ATTR_NSC : (!hit && !ans) ? ATTR_S : ATTR_NS;
        // Watermark area of flash stays secure whatever the regions say
        if (a >= FLASH_NS_LO && a <= NSC_FLASH_HI && a[27:0] >= wm_secure_lo[27:0]
            && a[27:0] <= wm_secure_hi[27:0]) return ATTR_S;
        return (x > fix_attr(a)) ? x : fix_attr(a);
    endfunction : fin_attr

    task automatic acc(input logic [31:0] a, input logic s);
        attr_t e;
        @(posedge clock);
        {go, addr, sec} <= {1'b1, a, s};
        @(posedge clock);
        go <= 1'b0;
        @(posedge clock);
        e = fin_attr(a);
        #1;
        if (!tz) check({verdict.violation, verdict.attr}, {1'b0, ATTR_NS});
        else check(verdict, {!s && e != ATTR_NS, e, fix_attr(a) == ATTR_NSC});
    endtask : acc

    task automatic wr_region(input int i, input region_t d);
        @(posedge clock);
        {region_we, region_idx, region_wdata} <= {1'b1, i[2:0], d};
        @(posedge clock);
        region_we <= 1'b0;
        rg[i] = d;
    endtask : wr_region

    task automatic cfg_load;
        @(posedge clock);
        v = $random(seed);
        {cfg_we, periph_sec_wdata, periph_priv_wdata, sram_sec_wdata} <= {1'b1, v, v[5]};
        {gpio_sec_wdata, irq_sec_wdata, blk_flash_sec_wdata} <= {$random(seed), ~v, v[6]};
        @(posedge clock);
        cfg_we <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        if (!tz) begin
            defaults();
        end else begin
            check({periph_secure, periph_priv}, v);
            check({gpio_secure, irq_secure}, {gpio_sec_wdata, irq_sec_wdata});
            check({sram_secure, blk_flash_secure}, {v[5], v[6]});
        end
    endtask : cfg_load

    initial begin
        {rst_n, go, sec, region_we, all_ns_we, all_ns_wdata, cfg_we, viol_en_we, pend} = '0;
        {sram_sec_wdata, blk_flash_sec_wdata, viol_src, viol_en_wdata, viol_clr} = '0;
        {flash_option_word, boot_addr, addr, region_idx, region_wdata} = '0;
        {periph_sec_wdata, periph_priv_wdata, gpio_sec_wdata, irq_sec_wdata} = '0;
        wm_secure_lo = 32'h0C00_0000;
        wm_secure_hi = 32'h0C0F_FFFF;
        do_reset(1'b0);
        boot(32'h0800_0000, 1'b1);
        cfg_load();
        acc(32'h2000_0000, 1'b0);
        $display("test partition_off done");
        do_reset(1'b1);
        boot(32'h0800_0000, 1'b0);
        boot(32'h0C00_0000, 1'b1);
        acc(32'h2000_0000, 1'b0);
        acc(32'h0800_0000, 1'b1);
        repeat (2) @(posedge clock);
        #1 check(viol_irq, 1'b0);
        $display("test reset_state done");
        @(posedge clock);
        {all_ns_we, all_ns_wdata} <= 2'h3;
        @(posedge clock);
        all_ns_we <= 1'b0;
        ans = 1'b1;
        foreach (corner[i]) begin
            acc(corner[i], 1'b0);
            acc(corner[i], 1'b1);
        end
        $display("test fixed_map done");
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            r = '{enable: v[0] | v[1], base: $random(seed) & 32'hEFFF_FFFF, limit: '0,
                  callable: v[2]};
            r.limit = r.base + (v & 32'h00FF_FFF0);
            wr_region(i, r);
        end
        foreach (rg[i]) begin
            acc(rg[i].limit, 1'b0);
            acc(rg[i].limit + 32'h1, 1'b0);
        end
        repeat (60) begin
            v = $random(seed);
            pick = v[3] ? rg[v[2:0]].base + {12'h0, v[31:12]} : $random(seed);
            acc(pick, v[4]);
        end
        $display("test regions done");
        repeat (3) cfg_load();
        $display("test config done");
        @(posedge clock);
        {viol_en_we, viol_en_wdata, viol_clr} <= {1'b1, 8'hFF, 8'hFF};
        @(posedge clock);
        {viol_en_we, viol_clr} <= 9'h0;
        repeat (2) @(posedge clock);
        #1 check(viol_pending, 8'h00);
        repeat (8) begin
            v = $random(seed);
            @(posedge clock);
            {viol_src, viol_clr} <= v[15:0];
            @(posedge clock);
            {viol_src, viol_clr} <= 16'h0;
            // A source firing with its own clear must stay pending
            pend = (pend & ~v[7:0]) | v[15:8];
            repeat (2) @(posedge clock);
            #1 check({viol_irq, viol_pending}, {|pend, pend});
        end
        acc(32'hE000_0000, 1'b0);
        repeat (2) @(posedge clock);
        #1 check(viol_pending[0], 1'b1);
        $display("test collector done");
        print_verdict();
    end
endmodule : testbench
